// *** flash_defs.vh ***
// Constants for the serial flash pause control and array map.
// Included by bare name; holds definitions only.
`ifndef FLASH_DEFS_VH
`define FLASH_DEFS_VH

// Array geometry
`define ADDR_W 21
`define SECTOR_LSB 16
`define SUBSEC_LSB 12
`define PAGE_LSB 8
`define SECTOR_W 5
`define SUBSEC_W 9
`define PAGE_W 13
`define OTP_ADDR_W 6
`define OTP_BYTES 64

// Erase kinds; code 0 is a page request and is refused
`define ERASE_NONE 2'h0
`define ERASE_SUB 2'h1
`define ERASE_SECT 2'h2
`define ERASE_BULK 2'h3

// Synchroniser reset levels
`define IDLE_CS_N 1'b1
`define IDLE_PAUSE_N 1'b1
`define IDLE_SCLK 1'b0

// Internal write, program or erase cycle length
`define CLK_PERIOD_NS 50
`define OP_CYCLE_NS 10000
`define OP_CYCLES (`OP_CYCLE_NS / `CLK_PERIOD_NS)
`define OP_CNT_W 8

`endif

// *** flash_pause_checker.sv ***
// Checker on pause, internal cycle and map ports of the flash block.
// Assumes a single clock mclk_i and async reset rst_i.
`timescale 1ns/1ns
`default_nettype none
module flash_pause_checker
(
  input wire mclk_i,
  input wire rst_i,
  input wire paused_o,
  input wire serial_out_oe_o,
  input wire rx_valid_o,
  input wire if_reset_o,
  input wire op_start_i,
  input wire op_busy_o,
  input wire [20:0] addr_i,
  input wire [4:0] sector_o,
  input wire [8:0] subsector_o,
  input wire [12:0] page_o,
  input wire [7:0] prog_old_i,
  input wire [7:0] prog_new_i,
  input wire [7:0] prog_result_o,
  input wire [1:0] erase_kind_i,
  input wire erase_ok_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  property p_oe_off;
    paused_o |-> !serial_out_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven in pause");
  property p_no_rx;
    paused_o |-> !rx_valid_o;
  endproperty
  a_no_rx: assert property (p_no_rx)
    else $error("byte taken in pause");
  property p_rst_out;
    if_reset_o |-> !paused_o;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("pause kept after deselect");
  property p_start;
    op_start_i && !op_busy_o |=> op_busy_o;
  endproperty
  a_start: assert property (p_start)
    else $error("cycle not started");
  // Fixed length, whatever the pins do meanwhile
  property p_busy;
    $rose(op_busy_o) |-> ##199 op_busy_o ##1 !op_busy_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("cycle length wrong");
  property p_map;
    1'b1 |=> {sector_o, subsector_o, page_o} ==
      $past({addr_i[20:16], addr_i[20:12], addr_i[20:8]});
  endproperty
  a_map: assert property (p_map)
    else $error("address map wrong");
  property p_prog;
    1'b1 |=> prog_result_o == $past(prog_old_i & prog_new_i);
  endproperty
  a_prog: assert property (p_prog)
    else $error("program set a bit");
  property p_erase;
    erase_kind_i == 2'h0 |=> !erase_ok_o;
  endproperty
  a_erase: assert property (p_erase)
    else $error("page erase accepted");
  c_pause: cover property ($rose(paused_o));
  c_ifrst: cover property (if_reset_o);
  c_busy: cover property ($rose(op_busy_o));
endmodule // flash_pause_checker
bind flash_pause_ctl flash_pause_checker flash_pause_checker_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .paused_o(paused_o),
  .serial_out_oe_o(serial_out_oe_o), .rx_valid_o(rx_valid_o),
  .if_reset_o(if_reset_o), .op_start_i(op_start_i),
  .op_busy_o(op_busy_o), .addr_i(addr_i), .sector_o(sector_o),
  .subsector_o(subsector_o), .page_o(page_o),
  .prog_old_i(prog_old_i), .prog_new_i(prog_new_i),
  .prog_result_o(prog_result_o), .erase_kind_i(erase_kind_i),
  .erase_ok_o(erase_ok_o));
`default_nettype wire

// *** flash_pause_ctl.v ***
// Serial flash interface with pause control and array address map.
// Assumes the host drives select, serial clock, pause and data in as
// asynchronous pins; the core supplies read bytes and old array data.
//
// Function
// [R1] Pause never aborts a status write, program or erase cycle running.
// [R2] Host asserts pause only while chip select is low.
// [R3] Pause starts on pause falling while serial clock is low.
// [R4] Pause ends on pause rising while serial clock is low.
// [R5] Pause falling with clock high takes effect once clock goes low.
// [R6] Pause rising with clock high ends pause once clock goes low.
// [R7] Serial output is released to high impedance while paused.
// [R8] Serial input and clock are ignored while paused; state frozen.
// [R9] Host should keep chip select low for the whole pause.
// [R10] Deselect during pause resets interface and drops partial transfer.
// [R11] After such reset host raises pause before selecting again.
// [R12] Reselect with pause high after that reset does not re-enter pause.
// [R13] Main array holds 2097152 byte locations of 8 bits.
// [R14] Array splits into 512 subsectors of 4 Kbytes each.
// [R15] Array splits into 32 sectors of 64 Kbytes, sixteen subsectors each.
// [R16] Array splits into 8192 pages of 256 bytes each.
// [R17] A 64-byte one-time area lies outside the main address space.
// [R18] Pages program singly and programming only clears bits.
// [R19] Erase covers subsector, sector or whole array, never one page.
// [R20] Bits travel MSB first, sampled on rising clock while selected.
// [R21] Address bits 20:16 sector, 20:12 subsector, 20:8 page.
`timescale 1ns/1ns
`default_nettype none
`include "flash_defs.vh"

module flash_pause_ctl
(
  input wire mclk_i,
  input wire rst_i,
  // Serial pins
  input wire cs_n_i,
  input wire sclk_i,
  input wire pause_n_i,
  input wire serial_in_i,
  output wire serial_out_o,
  output wire serial_out_oe_o,
  // Received bytes and link state
  output wire [7:0] rx_byte_o,
  output wire rx_valid_o,
  output wire paused_o,
  output wire if_reset_o,
  // Bytes to send
  input wire [7:0] tx_byte_i,
  input wire tx_load_i,
  // Internal cycle
  input wire op_start_i,
  output wire op_busy_o,
  // Array map
  input wire [20:0] addr_i,
  output wire [4:0] sector_o,
  output wire [8:0] subsector_o,
  output wire [12:0] page_o,
  input wire otp_sel_i,
  output wire [5:0] otp_offset_o,
  output wire otp_hit_o,
  // Program merge
  input wire [7:0] prog_old_i,
  input wire [7:0] prog_new_i,
  output wire [7:0] prog_result_o,
  // Erase range
  input wire [1:0] erase_kind_i,
  output wire [20:0] erase_lo_o,
  output wire [20:0] erase_hi_o,
  output wire erase_ok_o
);

localparam [1:0] ST_ACTIVE = 2'h0;
localparam [1:0] ST_PAUSED = 2'h1;
localparam [1:0] ST_LOCKOUT = 2'h2;
localparam integer OP_LAST_INT = `OP_CYCLES - 1;
localparam [`OP_CNT_W-1:0] OP_LAST = OP_LAST_INT[`OP_CNT_W-1:0];

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers, one per asynchronous input
wire [3:0] pin_raw;
wire [3:0] pin_sync_lvl;
localparam [3:0] PIN_RST = {`IDLE_CS_N, `IDLE_PAUSE_N, `IDLE_SCLK, 1'b0};
assign pin_raw = {cs_n_i, pause_n_i, sclk_i, serial_in_i};

genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1)
  begin : g_sync
    pin_sync #(.RST_VAL(PIN_RST[gi])) u_sync
    (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .pin_i(pin_raw[gi]),
      .level_o(pin_sync_lvl[gi])
    );
  end
endgenerate

wire cs_n_s = pin_sync_lvl[3];
wire pause_n_s = pin_sync_lvl[2];
wire sclk_s = pin_sync_lvl[1];
wire din_s = pin_sync_lvl[0];

////////////////////////////////////////////////////////////////////////////
// Pause state machine
reg [1:0] state_reg;
reg [1:0] state_next;
reg if_reset_reg;
reg if_reset_next;

// Level test on pause and clock: an edge seen with clock high waits
// until the clock is low, so deferral needs no separate tracking.
always @*
begin
  state_next = state_reg;
  if_reset_next = 1'b0;
  case (state_reg)
    ST_ACTIVE:
    begin
      if (!cs_n_s && !pause_n_s && !sclk_s) // [R2] [R3] [R5]
        state_next = ST_PAUSED;
    end
    ST_PAUSED:
    begin
      if (cs_n_s)
      begin
        state_next = ST_LOCKOUT; // [R10]
        if_reset_next = 1'b1;
      end
      else if (pause_n_s && !sclk_s) // [R4] [R6]
        state_next = ST_ACTIVE;
    end
    ST_LOCKOUT:
    begin
      // Stay out of pause until pause has been seen high
      if (pause_n_s) // [R12] [R11]
        state_next = ST_ACTIVE;
    end
    default:
      state_next = ST_ACTIVE;
  endcase
end

always @(posedge mclk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    state_reg <= ST_ACTIVE;
    if_reset_reg <= 1'b0;
  end
  else
  begin
    state_reg <= state_next;
    if_reset_reg <= if_reset_next;
  end
end

wire paused = (state_reg == ST_PAUSED);

////////////////////////////////////////////////////////////////////////////
// Serial clock edge detection on the filtered level
reg sclk_prev_reg;

always @(posedge mclk_i or posedge rst_i)
begin
  if (rst_i)
    sclk_prev_reg <= `IDLE_SCLK;
  else
    sclk_prev_reg <= sclk_s;
end

// Edges count only when selected, not paused and not locked out
wire link_live = !cs_n_s && (state_reg == ST_ACTIVE);
wire sclk_rise = link_live && sclk_s && !sclk_prev_reg; // [R8]
wire sclk_fall = link_live && !sclk_s && sclk_prev_reg; // [R8]

////////////////////////////////////////////////////////////////////////////
// Receive shifter, MSB first
reg [6:0] rx_shift_reg;
reg [2:0] bit_cnt_reg;
reg [7:0] rx_byte_reg;
reg rx_valid_reg;

always @(posedge mclk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    rx_shift_reg <= 7'h00;
    bit_cnt_reg <= 3'h0;
    rx_byte_reg <= 8'h00;
    rx_valid_reg <= 1'b0;
  end
  else
  begin
    rx_valid_reg <= 1'b0;
    // Deselect drops any partial byte, paused or not
    if (cs_n_s)
    begin
      rx_shift_reg <= 7'h00; // [R10]
      bit_cnt_reg <= 3'h0;
    end
    else if (sclk_rise)
    begin
      rx_shift_reg <= {rx_shift_reg[5:0], din_s}; // [R20]
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7)
      begin
        rx_byte_reg <= {rx_shift_reg, din_s};
        rx_valid_reg <= 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Transmit shifter, MSB first, advanced on falling serial clock
reg [7:0] tx_shift_reg;
reg tx_active_reg;

always @(posedge mclk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    tx_shift_reg <= 8'h00;
    tx_active_reg <= 1'b0;
  end
  else if (cs_n_s)
  begin
    tx_shift_reg <= 8'h00; // [R10]
    tx_active_reg <= 1'b0;
  end
  else if (tx_load_i)
  begin
    tx_shift_reg <= tx_byte_i;
    tx_active_reg <= 1'b1;
  end
  else if (sclk_fall && tx_active_reg)
    tx_shift_reg <= {tx_shift_reg[6:0], 1'b0}; // [R20]
end

// Output floats while paused; enable high means the pin is driven
assign serial_out_o = tx_shift_reg[7];
assign serial_out_oe_o = tx_active_reg && link_live; // [R7]

////////////////////////////////////////////////////////////////////////////
// Internal cycle timer; pause and select play no part in it
reg [`OP_CNT_W-1:0] op_cnt_reg;
reg op_busy_reg;

always @(posedge mclk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    op_cnt_reg <= {`OP_CNT_W{1'b0}};
    op_busy_reg <= 1'b0;
  end
  else if (op_busy_reg)
  begin
    // Runs to the end regardless of pause state
    if (op_cnt_reg == OP_LAST) // [R1]
      op_busy_reg <= 1'b0;
    op_cnt_reg <= op_cnt_reg + {{(`OP_CNT_W-1){1'b0}}, 1'b1};
  end
  else if (op_start_i)
  begin
    op_busy_reg <= 1'b1;
    op_cnt_reg <= {`OP_CNT_W{1'b0}};
  end
end

////////////////////////////////////////////////////////////////////////////
// Address map and array operations, registered
reg [4:0] sector_reg;
reg [8:0] subsector_reg;
reg [12:0] page_reg;
reg [5:0] otp_offset_reg;
reg otp_hit_reg;
reg [7:0] prog_result_reg;
reg [20:0] erase_lo_reg;
reg [20:0] erase_hi_reg;
reg erase_ok_reg;

// Sector of 16 subsectors, page of 256 bytes, 21 bits cover 2 Mbytes
always @(posedge mclk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    sector_reg <= 5'h00;
    subsector_reg <= 9'h000;
    page_reg <= 13'h0000;
    otp_offset_reg <= 6'h00;
    otp_hit_reg <= 1'b0;
    prog_result_reg <= 8'hff;
  end
  else
  begin
    sector_reg <= addr_i[20:`SECTOR_LSB]; // [R15] [R21] [R13]
    subsector_reg <= addr_i[20:`SUBSEC_LSB]; // [R14] [R21]
    page_reg <= addr_i[20:`PAGE_LSB]; // [R16] [R21]
    // One-time area has its own 64-byte space
    otp_offset_reg <= addr_i[`OTP_ADDR_W-1:0]; // [R17]
    otp_hit_reg <= otp_sel_i; // [R17]
    // Program may only pull ones to zero
    prog_result_reg <= prog_old_i & prog_new_i; // [R18]
  end
end

// Erase range, aligned down to the chosen granule
always @(posedge mclk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    erase_lo_reg <= 21'h000000;
    erase_hi_reg <= 21'h000000;
    erase_ok_reg <= 1'b0;
  end
  else
  begin
    case (erase_kind_i)
      `ERASE_SUB:
      begin
        erase_lo_reg <= {addr_i[20:`SUBSEC_LSB], 12'h000}; // [R19]
        erase_hi_reg <= {addr_i[20:`SUBSEC_LSB], 12'hfff};
        erase_ok_reg <= 1'b1;
      end
      `ERASE_SECT:
      begin
        erase_lo_reg <= {addr_i[20:`SECTOR_LSB], 16'h0000}; // [R19]
        erase_hi_reg <= {addr_i[20:`SECTOR_LSB], 16'hffff};
        erase_ok_reg <= 1'b1;
      end
      `ERASE_BULK:
      begin
        erase_lo_reg <= 21'h000000; // [R19]
        erase_hi_reg <= 21'h1fffff;
        erase_ok_reg <= 1'b1;
      end
      default:
      begin
        // No page-sized erase exists
        erase_lo_reg <= 21'h000000; // [R19]
        erase_hi_reg <= 21'h000000;
        erase_ok_reg <= 1'b0;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// Output assignments
assign rx_byte_o = rx_byte_reg;
assign rx_valid_o = rx_valid_reg;
assign paused_o = paused;
assign if_reset_o = if_reset_reg;
assign op_busy_o = op_busy_reg;
assign sector_o = sector_reg;
assign subsector_o = subsector_reg;
assign page_o = page_reg;
assign otp_offset_o = otp_offset_reg;
assign otp_hit_o = otp_hit_reg;
assign prog_result_o = prog_result_reg;
assign erase_lo_o = erase_lo_reg;
assign erase_hi_o = erase_hi_reg;
assign erase_ok_o = erase_ok_reg;

endmodule // flash_pause_ctl

`default_nettype wire

// *** pin_sync.v ***
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous pin input and the block clock mclk_i.
`timescale 1ns/1ns
`default_nettype none

module pin_sync
#(
  parameter [0:0] RST_VAL = 1'b0
)
(
  input wire mclk_i,
  input wire rst_i,
  input wire pin_i,
  output wire level_o
);

reg ff1_reg;
reg ff2_reg;
reg ff3_reg;
reg level_reg;

////////////////////////////////////////////////////////////////////////////
// First stage feeds only the second; output moves once stages 2 and 3 agree
always @(posedge mclk_i or posedge rst_i)
begin
  if (rst_i)
  begin
    ff1_reg <= RST_VAL;
    ff2_reg <= RST_VAL;
    ff3_reg <= RST_VAL;
    level_reg <= RST_VAL;
  end
  else
  begin
    ff1_reg <= pin_i;
    ff2_reg <= ff1_reg;
    ff3_reg <= ff2_reg;
    if (ff2_reg == ff3_reg)
      level_reg <= ff3_reg;
  end
end

assign level_o = level_reg;

endmodule // pin_sync

`default_nettype wire

// *** spi_host.sv ***
// Host model driving select, serial clock, pause and data pins.
// Assumes mclk_i from the bench; pins move just after its rising edge.
`timescale 1ns/1ns
`default_nettype none
module spi_host
(
  input wire logic mclk_i,
  output var logic cs_n_o,
  output var logic sclk_o,
  output var logic pause_n_o,
  output var logic data_o
);
  // Idle: deselected, clock low and still between frames
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    pause_n_o = 1'b1;
    data_o = 1'b0;
  end
  ////////////////////////////////////////
  // Half of a 400 ns serial period
  task automatic half(input logic v);
    repeat (4) @(posedge mclk_i);
    sclk_o <= v;
  endtask
  // Released data shows the inverse, not a stale bit
  task automatic sel(input logic on);
    @(posedge mclk_i);
    cs_n_o <= !on;
    if (!on)
      data_o <= !data_o;
  endtask
  // Callers lower pause only while selected
  task automatic hold(input logic v);
    @(posedge mclk_i);
    pause_n_o <= v;
  endtask
  // Top n bits of b, set while the clock is low
  task automatic send(input logic [7:0] b, input int n);
    int i;
    for (i = 7; i > 7 - n; i--)
    begin
      @(posedge mclk_i);
      data_o <= b[i];
      // Four clocks low, four high: a 400 ns serial period
      repeat (3) @(posedge mclk_i);
      sclk_o <= 1'b1;
      half(1'b0);
    end
  endtask
endmodule // spi_host
`default_nettype wire

// *** test_flash_pause_ctl.sv ***
// Bench for flash pause control and array map.
// Assumes spi_host drives the serial pins; map cases come from a table.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module test_flash_pause_ctl;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic op_start_i = 1'b0;
  logic otp_sel_i = 1'b0;
  logic [20:0] addr_i = 21'h000000;
  // All ones in reset match the merge's reset value for the checker
  logic [7:0] prog_old_i = 8'hff;
  logic [7:0] prog_new_i = 8'hff;
  logic [7:0] tx_byte_i = 8'h00;
  logic tx_load_i = 1'b0;
  logic [1:0] erase_kind_i = 2'h0;
  wire logic cs_n_i, sclk_i, pause_n_i, serial_in_i;
  wire logic serial_out_oe_o, rx_valid_o, paused_o, if_reset_o;
  wire logic op_busy_o, otp_hit_o, erase_ok_o;
  wire logic [7:0] rx_byte_o, prog_result_o;
  wire logic serial_out_o;
  wire logic [5:0] otp_offset_o;
  wire logic [4:0] sector_o;
  wire logic [8:0] subsector_o;
  wire logic [12:0] page_o;
  wire logic [20:0] erase_lo_o, erase_hi_o;
  int error_cnt = 0;
  int n_compared = 0;
  int rst_seen = 0;
  int busy_cnt = 0;
  int k;
  logic [20:0] m;
  typedef struct packed {logic [20:0] a; logic [4:0] s; logic [8:0] u;
    logic [12:0] p; logic [7:0] o; logic [7:0] n; logic [7:0] r;} row_t;
  row_t rows [4];
  spi_host spi_host_i (.mclk_i(mclk_i), .cs_n_o(cs_n_i), .sclk_o(sclk_i),
    .pause_n_o(pause_n_i), .data_o(serial_in_i));
  flash_pause_ctl flash_pause_ctl_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .cs_n_i(cs_n_i), .sclk_i(sclk_i), .pause_n_i(pause_n_i),
    .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o), .rx_byte_o(rx_byte_o),
    .rx_valid_o(rx_valid_o), .paused_o(paused_o), .if_reset_o(if_reset_o),
    .tx_byte_i(tx_byte_i), .tx_load_i(tx_load_i), .op_start_i(op_start_i),
    .op_busy_o(op_busy_o), .addr_i(addr_i), .sector_o(sector_o),
    .subsector_o(subsector_o), .page_o(page_o), .otp_sel_i(otp_sel_i),
    .otp_offset_o(otp_offset_o), .otp_hit_o(otp_hit_o),
    .prog_old_i(prog_old_i), .prog_new_i(prog_new_i),
    .prog_result_o(prog_result_o), .erase_kind_i(erase_kind_i),
    .erase_lo_o(erase_lo_o), .erase_hi_o(erase_hi_o),
    .erase_ok_o(erase_ok_o));
  ////////////////////////////////////////
  initial
    forever #25 mclk_i = ~mclk_i;
  // Pulse and cycle counters, sampled mid-cycle
  always @(negedge mclk_i)
  begin
    rst_seen += (if_reset_o === 1'b1);
    busy_cnt += (op_busy_o === 1'b1);
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // Bounded wait for a received byte
  task automatic rx_chk(input logic [7:0] e);
    int t;
    logic seen;
    seen = 1'b0;
    for (t = 0; t < 120 && !seen; t++)
      @(negedge mclk_i) seen = (rx_valid_o === 1'b1);
    `CHK(seen, 1'b1)
    `CHK(rx_byte_o, e)
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Run far longer than the tests need, then give up
  initial
  begin
    #500000;
    error_cnt++;
    finish_test();
  end
  initial
  begin
    rows[0] = '{21'h1fffff, 5'h1f, 9'h1ff, 13'h1fff, 8'hff, 8'h5a, 8'h5a};
    rows[1] = '{21'h14f123, 5'h14, 9'h14f, 13'h14f1, 8'h0f, 8'hf0, 8'h00};
    rows[2] = '{21'h0f0fff, 5'h0f, 9'h0f0, 13'h0f0f, 8'h3c, 8'hff, 8'h3c};
    rows[3] = '{21'h000000, 5'h00, 9'h000, 13'h0000, 8'h00, 8'hff, 8'h00};
    tick(12);
    `CHK(serial_out_oe_o, 1'b0)
    `CHK(prog_result_o, 8'hff)
    @(posedge mclk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
      for (k = 0; k < 4; k++)
      begin
        @(posedge mclk_i);
        addr_i <= rows[i].a;
        prog_old_i <= rows[i].o;
        prog_new_i <= rows[i].n;
        erase_kind_i <= k[1:0];
        otp_sel_i <= k[0];
        tick(2);
        m = (k == 1) ? 21'h000fff : (k == 2) ? 21'h00ffff : 21'h1fffff;
        `CHK(sector_o, rows[i].s)
        `CHK(subsector_o, rows[i].u)
        `CHK(page_o, rows[i].p)
        `CHK(prog_result_o, rows[i].r)
        `CHK(otp_hit_o, k[0])
        `CHK(otp_offset_o, rows[i].a[5:0])
        `CHK(erase_ok_o, k != 0)
        if (k != 0)
        begin
          `CHK(erase_lo_o, rows[i].a & ~m)
          `CHK(erase_hi_o, rows[i].a | m)
        end
        else
          `CHK(erase_hi_o, 21'h000000)
      end
    // Deferred entry and exit with the clock high, a byte queued to send
    spi_host_i.sel(1'b1);
    tick(6);
    @(posedge mclk_i);
    tx_byte_i <= 8'h97;
    tx_load_i <= 1'b1;
    @(posedge mclk_i);
    tx_load_i <= 1'b0;
    tick(1);
    `CHK(serial_out_oe_o, 1'b1)
    `CHK(serial_out_o, 1'b1)
    spi_host_i.send(8'hf0, 3);
    spi_host_i.half(1'b1);
    spi_host_i.hold(1'b0);
    tick(8);
    `CHK(paused_o, 1'b0)
    `CHK(serial_out_o, 1'b1)
    spi_host_i.half(1'b0);
    tick(8);
    `CHK(paused_o, 1'b1)
    `CHK(serial_out_oe_o, 1'b0)
    spi_host_i.send(8'h00, 2);
    spi_host_i.half(1'b1);
    spi_host_i.hold(1'b1);
    tick(8);
    `CHK(paused_o, 1'b1)
    spi_host_i.half(1'b0);
    tick(8);
    `CHK(paused_o, 1'b0)
    `CHK(serial_out_oe_o, 1'b1)
    `CHK(serial_out_o, 1'b0)
    fork spi_host_i.send(8'h00, 4); rx_chk(8'hf0); join
    spi_host_i.sel(1'b0);
    // Deselect in pause while an internal cycle runs
    @(posedge mclk_i);
    op_start_i <= 1'b1;
    @(posedge mclk_i);
    op_start_i <= 1'b0;
    spi_host_i.sel(1'b1);
    spi_host_i.send(8'hff, 3);
    spi_host_i.hold(1'b0);
    tick(8);
    `CHK(paused_o, 1'b1)
    `CHK(op_busy_o, 1'b1)
    spi_host_i.sel(1'b0);
    tick(20);
    `CHK(rst_seen, 1)
    `CHK(paused_o, 1'b0)
    spi_host_i.hold(1'b1);
    spi_host_i.sel(1'b1);
    tick(8);
    `CHK(paused_o, 1'b0)
    fork spi_host_i.send(8'h3c, 8); rx_chk(8'h3c); join
    spi_host_i.sel(1'b0);
    tick(120);
    `CHK(busy_cnt, 200)
    finish_test();
  end
endmodule // test_flash_pause_ctl
`default_nettype wire
